// File: nqr_pkg.sv
// shared constants for the queue management and rebuild assist block
package nqr_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_OUTST = 8'h08;
  localparam logic [7:0] OFF_QLOG0 = 8'h0c;
  localparam logic [7:0] OFF_QLOG1 = 8'h10;
  localparam logic [7:0] OFF_QVER = 8'h14;
  localparam logic [7:0] OFF_RBLEN = 8'h18;
  localparam logic [7:0] OFF_RBMASK = 8'h1c;
  localparam logic [7:0] OFF_RBDIS = 8'h20;
  localparam logic [7:0] OFF_QESNS = 8'h24;
  localparam logic [7:0] OFF_QELBA_LO = 8'h28;
  localparam logic [7:0] OFF_QELBA_HI = 8'h2c;
  localparam logic [7:0] OFF_QEFIN_LO = 8'h30;
  localparam logic [7:0] OFF_QEFIN_HI = 8'h34;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_NCQ_EN = 0;
  localparam int CTRL_RB_EN = 1;
  localparam logic CTRL_NCQ_EN_RST = 1'b1;
  localparam logic CTRL_RB_EN_RST = 1'b0;
  localparam int STAT_WNC = 0;
  localparam int STAT_RNC = 1;
  localparam int STAT_ERR = 2;
  localparam int STAT_QLOG = 3;
  localparam int FEAT_WNC = 4;
  localparam int FEAT_RNC = 5;
  // ----------------------------------------------------------------
  // command encodings and log contents
  // ----------------------------------------------------------------
  localparam logic [3:0] SUB_ABORT = 4'h0;
  localparam logic [3:0] SUB_DEADLINE = 4'h1;
  localparam logic [3:0] ABT_ALL = 4'h0;
  localparam logic [3:0] ABT_STREAM = 4'h1;
  localparam logic [3:0] ABT_NONSTREAM = 4'h2;
  localparam logic [3:0] ABT_SELECTED = 4'h3;
  localparam logic [31:0] QLOG_VERSION = 32'h0000_0001;
  localparam logic [7:0] QM_LOG_ADDR = 8'h12;
  localparam logic [7:0] RB_LOG_ADDR = 8'h15;
  localparam logic [3:0] SENSE_KEY_ABORTED = 4'hb;
  localparam logic [15:0] ASC_MULTI_READ = 16'h1103;
endpackage

// File: nqr_core.sv
// queue management command, its log page and rebuild assist logic
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps

module nqr_core #(
  parameter int QDEPTH = 32,
  parameter int ELEM_BYTES = 1,
  parameter logic [31:0] ELEM_MASK = 32'h0000_00ff,
  parameter logic [4:0] SUP_ABORT = 5'h1f,
  parameter logic [2:0] SUP_DL = 3'h7
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic soft_reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acc_valid,
  input wire logic [4:0] acc_tag,
  input wire logic acc_stream,
  input wire logic done_valid,
  input wire logic [4:0] done_tag,
  input wire logic qm_valid,
  input wire logic [4:0] qm_tag,
  input wire logic [4:0] target_queue_tag,
  input wire logic [7:0] qm_feat,
  output logic sdb_valid,
  output logic [31:0] sdb_act,
  output logic resp_valid,
  output logic resp_err,
  output logic resp_abrt,
  output logic write_not_continue_bit,
  output logic read_not_continue_bit,
  input wire logic sec_valid,
  input wire logic sec_write,
  input wire logic [47:0] sec_lba,
  input wire logic [4:0] sec_elem,
  input wire logic sec_pred,
  input wire logic rebuild_assist_bypass_bit,
  input wire logic sec_last,
  output logic sec_err,
  output logic qlog_valid
);
  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  initial
  begin
    if (QDEPTH < 1 || QDEPTH > 32)
      $error("QDEPTH must be 1 to 32");
    if (ELEM_BYTES < 1 || ELEM_BYTES > 4)
      $error("ELEM_BYTES must be 1 to 4");
  end

  localparam logic [31:0] LEN_MASK = (ELEM_BYTES == 4) ? 32'hffff_ffff :
    ((32'h1 << (8 * ELEM_BYTES)) - 32'h1);
  localparam logic [31:0] EMASK = ELEM_MASK & LEN_MASK;

  logic ncq_en_q;
  logic rb_en_q;
  logic wnc_q;
  logic rnc_q;
  logic err_q;
  logic [31:0] out_q;
  logic [31:0] stream_q;
  logic [31:0] dis_q;
  logic qlog_q;
  logic [47:0] qe_lba_q;
  logic [47:0] qe_fin_q;
  logic [3:0] qe_key_q;
  logic [15:0] qe_asc_q;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic [3:0] sub;
  logic [3:0] typ;
  logic bad_tag;
  logic [31:0] sel_mask;
  logic abt_sup;
  logic dl_sup;
  logic qm_ok;
  logic qm_bad;
  logic [31:0] kill;
  logic [31:0] own_bit;

  always_comb
  begin
    sub = qm_feat[3:0];
    typ = qm_feat[7:4];
    own_bit = 32'h1 << qm_tag;
    bad_tag = (qm_tag == target_queue_tag) ||
      (int'(target_queue_tag) >= QDEPTH);
    sel_mask = 32'h0;
    abt_sup = 1'b0;
    unique case (typ)
      nqr_pkg::ABT_ALL:
      begin
        sel_mask = out_q;
        abt_sup = SUP_ABORT[1];
      end
      nqr_pkg::ABT_STREAM:
      begin
        sel_mask = out_q & stream_q;
        abt_sup = SUP_ABORT[2];
      end
      nqr_pkg::ABT_NONSTREAM:
      begin
        sel_mask = out_q & ~stream_q;
        abt_sup = SUP_ABORT[3];
      end
      nqr_pkg::ABT_SELECTED:
      begin
        sel_mask = out_q & (32'h1 << target_queue_tag);
        abt_sup = SUP_ABORT[4];
      end
      default:
      begin
        sel_mask = 32'h0;
        abt_sup = 1'b0;
      end
    endcase
    abt_sup = abt_sup & SUP_ABORT[0];
    // type bits above the two option bits are not defined
    dl_sup = SUP_DL[0] && (qm_feat[7:6] == 2'b00) &&
      (!qm_feat[nqr_pkg::FEAT_WNC] || SUP_DL[1]) &&
      (!qm_feat[nqr_pkg::FEAT_RNC] || SUP_DL[2]);
    qm_ok = 1'b0;
    qm_bad = 1'b0;
    kill = 32'h0;
    if (qm_valid)
    begin
      if (sub == nqr_pkg::SUB_ABORT)
      begin
        qm_ok = ncq_en_q && !bad_tag && abt_sup;
        kill = qm_ok ? sel_mask : 32'h0;
      end
      else if (sub == nqr_pkg::SUB_DEADLINE)
        qm_ok = ncq_en_q && !bad_tag && dl_sup;
      else
      begin
        // unknown subcommand also flushes the whole queue
        kill = out_q;
      end
      qm_bad = !qm_ok;
    end
  end

  // ----------------------------------------------------------------
  // outstanding queue
  // ----------------------------------------------------------------
  logic [31:0] acc_set;
  logic [31:0] done_clr;

  always_comb
  begin
    acc_set = acc_valid ? (32'h1 << acc_tag) : 32'h0;
    done_clr = done_valid ? (32'h1 << done_tag) : 32'h0;
  end

  // a tag accepted alongside the abort is added after the kill
  always_ff @(posedge core_clk)
  begin
    if (rst || soft_reset)
      out_q <= 32'h0;
    else
      out_q <= (out_q & ~kill & ~done_clr) | acc_set;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      stream_q <= 32'h0;
    else if (acc_valid)
      stream_q[acc_tag] <= acc_stream;
  end

  // ----------------------------------------------------------------
  // completion outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sdb_valid <= 1'b0;
      sdb_act <= 32'h0;
      resp_valid <= 1'b0;
      resp_err <= 1'b0;
      resp_abrt <= 1'b0;
    end
    else
    begin
      resp_valid <= qm_valid;
      resp_err <= qm_bad;
      resp_abrt <= qm_bad;
      sdb_valid <= qm_ok;
      sdb_act <= qm_ok ? (own_bit | kill) : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // deadline options
  // ----------------------------------------------------------------
  // only the power reset clears these, soft reset leaves them
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wnc_q <= 1'b0;
      rnc_q <= 1'b0;
    end
    else if (qm_ok && sub == nqr_pkg::SUB_DEADLINE)
    begin
      wnc_q <= qm_feat[nqr_pkg::FEAT_WNC];
      rnc_q <= qm_feat[nqr_pkg::FEAT_RNC];
    end
  end

  assign write_not_continue_bit = wnc_q;
  assign read_not_continue_bit = rnc_q;

  always_ff @(posedge core_clk)
  begin
    if (rst || soft_reset)
      err_q <= 1'b0;
    else if (qm_valid)
      err_q <= qm_bad;
  end

  // ----------------------------------------------------------------
  // rebuild assist sector path
  // ----------------------------------------------------------------
  logic elem_off;
  logic ra_active;
  logic hit;
  logic found_q;
  logic open_q;
  logic [47:0] first_q;
  logic [47:0] last_q;
  logic found_d;
  logic open_d;
  logic [47:0] first_d;
  logic [47:0] last_d;

  always_comb
  begin
    // bypassed reads see media prediction only
    ra_active = rb_en_q && (sec_write || !rebuild_assist_bypass_bit);
    elem_off = ra_active && dis_q[sec_elem];
    hit = sec_pred || elem_off;
    found_d = found_q;
    open_d = open_q;
    first_d = first_q;
    last_d = last_q;
    if (sec_valid && !sec_write && !rebuild_assist_bypass_bit && rb_en_q)
    begin
      if (hit && !found_q)
      begin
        found_d = 1'b1;
        open_d = 1'b1;
        first_d = sec_lba;
        last_d = sec_lba;
      end
      else if (hit && open_q && sec_lba == last_q + 48'h1)
        last_d = sec_lba;
      else
        open_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst || soft_reset || (sec_valid && sec_last))
    begin
      found_q <= 1'b0;
      open_q <= 1'b0;
      first_q <= 48'h0;
      last_q <= 48'h0;
    end
    else
    begin
      found_q <= found_d;
      open_q <= open_d;
      first_q <= first_d;
      last_q <= last_d;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      sec_err <= 1'b0;
    else
      sec_err <= sec_valid && hit;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      qlog_q <= 1'b0;
      qlog_valid <= 1'b0;
      qe_lba_q <= 48'h0;
      qe_fin_q <= 48'h0;
      qe_key_q <= 4'h0;
      qe_asc_q <= 16'h0;
    end
    else
    begin
      qlog_valid <= sec_valid && sec_last && found_d;
      if (sec_valid && sec_last && found_d)
      begin
        qlog_q <= 1'b1;
        qe_key_q <= nqr_pkg::SENSE_KEY_ABORTED;
        qe_asc_q <= nqr_pkg::ASC_MULTI_READ;
        qe_lba_q <= first_d;
        qe_fin_q <= last_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb slave, one wait-free access phase, data latched in setup
  // ----------------------------------------------------------------
  logic wr;
  logic [31:0] rd_mux;
  logic rd_bad;

  assign wr = psel && penable && pwrite;
  assign pready = psel && penable;

  always_comb
  begin
    rd_mux = 32'h0;
    rd_bad = 1'b0;
    unique case (paddr)
      nqr_pkg::OFF_CTRL:
      begin
        rd_mux[nqr_pkg::CTRL_NCQ_EN] = ncq_en_q;
        rd_mux[nqr_pkg::CTRL_RB_EN] = rb_en_q;
      end
      nqr_pkg::OFF_STAT:
      begin
        rd_mux[nqr_pkg::STAT_WNC] = wnc_q;
        rd_mux[nqr_pkg::STAT_RNC] = rnc_q;
        rd_mux[nqr_pkg::STAT_ERR] = err_q;
        rd_mux[nqr_pkg::STAT_QLOG] = qlog_q;
      end
      nqr_pkg::OFF_OUTST: rd_mux = out_q;
      // reserved fields stay zero
      nqr_pkg::OFF_QLOG0:
        rd_mux = {27'h0, SUP_ABORT};
      nqr_pkg::OFF_QLOG1: rd_mux = {29'h0, SUP_DL};
      nqr_pkg::OFF_QVER: rd_mux = nqr_pkg::QLOG_VERSION;
      nqr_pkg::OFF_RBLEN:
        rd_mux = 32'(ELEM_BYTES);
      nqr_pkg::OFF_RBMASK: rd_mux = EMASK;
      nqr_pkg::OFF_RBDIS: rd_mux = dis_q;
      nqr_pkg::OFF_QESNS: rd_mux = {12'h0, qe_key_q, qe_asc_q};
      nqr_pkg::OFF_QELBA_LO: rd_mux = qe_lba_q[31:0];
      nqr_pkg::OFF_QELBA_HI: rd_mux = {16'h0, qe_lba_q[47:32]};
      nqr_pkg::OFF_QEFIN_LO: rd_mux = qe_fin_q[31:0];
      nqr_pkg::OFF_QEFIN_HI: rd_mux = {16'h0, qe_fin_q[47:32]};
      default: rd_bad = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata <= pwrite ? 32'h0 : rd_mux;
      pslverr <= rd_bad;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ncq_en_q <= nqr_pkg::CTRL_NCQ_EN_RST;
      rb_en_q <= nqr_pkg::CTRL_RB_EN_RST;
    end
    else if (wr && paddr == nqr_pkg::OFF_CTRL)
    begin
      ncq_en_q <= pwdata[nqr_pkg::CTRL_NCQ_EN];
      rb_en_q <= pwdata[nqr_pkg::CTRL_RB_EN];
    end
  end

  // length and mask have no storage, so writes there fall away
  always_ff @(posedge core_clk)
  begin
    if (rst)
      dis_q <= 32'h0;
    else if (wr && paddr == nqr_pkg::OFF_RBDIS)
      dis_q <= pwdata & EMASK;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  chk_abort_own_tag: assert property (
    qm_ok |=> sdb_valid && ((sdb_act & $past(own_bit)) != 32'h0))
    else $error("own tag missing from completion");
  chk_abort_old_only: assert property (
    qm_valid && sub == nqr_pkg::SUB_ABORT |=>
      ((sdb_act & ~$past(out_q) & ~$past(own_bit)) == 32'h0))
    else $error("abort touched a later tag");
  chk_reject_flags: assert property (
    qm_valid && !ncq_en_q |=> resp_err && resp_abrt && !sdb_valid)
    else $error("disabled queue not rejected");
  chk_tag_clash: assert property (
    qm_valid && qm_tag == target_queue_tag |=> resp_abrt && !sdb_valid)
    else $error("tag clash not rejected");
  chk_reject_keeps: assert property (
    qm_bad && sub <= nqr_pkg::SUB_DEADLINE && !acc_valid && !done_valid
      && !soft_reset |=> out_q == $past(out_q))
    else $error("rejected command changed queue");
  chk_soft_keeps: assert property (
    soft_reset && !qm_valid |=> wnc_q == $past(wnc_q) && rnc_q == $past(rnc_q))
    else $error("soft reset lost deadline bits");
  chk_abort_ok: assert property (
    qm_valid && sub == nqr_pkg::SUB_ABORT && ncq_en_q && !bad_tag
      && abt_sup |=> sdb_valid && !resp_err)
    else $error("supported abort not successful");
  chk_dis_masked: assert property (
    (dis_q & ~EMASK) == 32'h0)
    else $error("unsupported element bit stored");
  chk_elem_error: assert property (
    sec_valid && rb_en_q && sec_write && dis_q[sec_elem] |=> sec_err)
    else $error("disabled element not erroring");
  chk_qlog_code: assert property (
    qlog_valid |-> qe_key_q == nqr_pkg::SENSE_KEY_ABORTED &&
      qe_asc_q == nqr_pkg::ASC_MULTI_READ && qe_fin_q >= qe_lba_q)
    else $error("queued error log wrong");
  chk_version: assert property (
    psel && !penable && !pwrite && paddr == nqr_pkg::OFF_QVER |=>
      prdata == nqr_pkg::QLOG_VERSION)
    else $error("log version word wrong");

  cov_abort_some: cover property (qm_ok && sub == nqr_pkg::SUB_ABORT
    && kill != 32'h0);
  cov_deadline: cover property (qm_ok && sub == nqr_pkg::SUB_DEADLINE);
  cov_qlog_run: cover property (qlog_valid && qe_fin_q != qe_lba_q);
  cov_reject: cover property (qm_bad);
endmodule

// File: nqr_host_model.sv
// host controller model issuing queued commands and sector traffic
`timescale 1ns/1ps
module nqr_host_model (
  input wire logic core_clk,
  output logic acc_valid,
  output logic [4:0] acc_tag,
  output logic acc_stream,
  output logic done_valid,
  output logic [4:0] done_tag,
  output logic qm_valid,
  output logic [4:0] qm_tag,
  output logic [4:0] target_queue_tag,
  output logic [7:0] qm_feat,
  output logic sec_valid,
  output logic sec_write,
  output logic [47:0] sec_lba,
  output logic [4:0] sec_elem,
  output logic sec_pred,
  output logic rebuild_assist_bypass_bit,
  output logic sec_last
);
  initial
  begin
    {acc_valid, acc_tag, acc_stream, done_valid, done_tag} = '0;
    {qm_valid, qm_tag, target_queue_tag, qm_feat} = '0;
    {sec_valid, sec_write, sec_lba, sec_elem, sec_pred} = '0;
    {rebuild_assist_bypass_bit, sec_last} = '0;
  end

  // ----------------------------------------------------------------
  // transfers
  // ----------------------------------------------------------------
  // released tags (except acc_tag after qm_cmd), features and LBAs are inverted so stale values never look valid
  task automatic accept(input logic [4:0] t, input logic s);
    @(posedge core_clk);
    acc_valid <= 1'b1;
    acc_tag <= t;
    acc_stream <= s;
    @(posedge core_clk);
    acc_valid <= 1'b0;
    acc_tag <= ~t;
  endtask

  task automatic qm_cmd(input logic [4:0] own, input logic [4:0] tgt,
    input logic [7:0] feat, input logic wa, input logic [4:0] at);
    @(posedge core_clk);
    qm_valid <= 1'b1;
    qm_tag <= own;
    target_queue_tag <= tgt;
    qm_feat <= feat;
    acc_valid <= wa;
    acc_tag <= at;
    acc_stream <= 1'b0;
    @(posedge core_clk);
    qm_valid <= 1'b0;
    acc_valid <= 1'b0;
    qm_tag <= ~own;
    target_queue_tag <= ~tgt;
    qm_feat <= ~feat;
  endtask

  task automatic sector(input logic [47:0] lba, input logic [4:0] el,
    input logic pr, input logic wr, input logic byp, input logic last);
    @(posedge core_clk);
    sec_valid <= 1'b1;
    sec_lba <= lba;
    sec_elem <= el;
    sec_pred <= pr;
    sec_write <= wr;
    rebuild_assist_bypass_bit <= byp;
    sec_last <= last;
    @(posedge core_clk);
    sec_valid <= 1'b0;
    sec_lba <= ~lba;
    sec_last <= 1'b0;
  endtask

  task automatic complete(input logic [4:0] t);
    @(posedge core_clk);
    done_valid <= 1'b1;
    done_tag <= t;
    @(posedge core_clk);
    done_valid <= 1'b0;
    done_tag <= ~t;
  endtask
endmodule

// File: ncq_queue_mgmt_rebuild_assist_tb_top.sv
// self-checking bench for the queue management and rebuild assist core
`timescale 1ns/1ps
module ncq_queue_mgmt_rebuild_assist_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic soft_reset = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, sdb_act;
  logic pready, pslverr, acc_valid, acc_stream, done_valid, qm_valid;
  logic [4:0] acc_tag, done_tag, qm_tag, target_queue_tag, sec_elem;
  logic [7:0] qm_feat;
  logic sdb_valid, resp_valid, resp_err, resp_abrt, sec_err, qlog_valid;
  logic write_not_continue_bit, read_not_continue_bit;
  logic sec_valid, sec_write, sec_pred, rebuild_assist_bypass_bit, sec_last;
  logic [47:0] sec_lba;
  logic qlog_seen = 1'b0;
  logic [1:0] dl_bits;
  int fail_count = 0;
  int n_checks = 0;

  always #5 core_clk = ~core_clk;
  assign dl_bits = {write_not_continue_bit, read_not_continue_bit};
  always @(posedge core_clk)
    if (qlog_valid === 1'b1)
      qlog_seen <= 1'b1;

  nqr_host_model u_host (.core_clk, .acc_valid, .acc_tag, .acc_stream,
    .done_valid, .done_tag, .qm_valid, .qm_tag, .target_queue_tag,
    .qm_feat, .sec_valid, .sec_write, .sec_lba, .sec_elem, .sec_pred,
    .rebuild_assist_bypass_bit, .sec_last);

  // small depth and mask so invalid tags and masking are reachable
  nqr_core #(.QDEPTH(16), .ELEM_BYTES(1), .ELEM_MASK(32'h0000_000f),
    .SUP_ABORT(5'h1f), .SUP_DL(3'h7)) i_dut (.core_clk, .rst, .soft_reset,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .acc_valid, .acc_tag, .acc_stream, .done_valid, .done_tag, .qm_valid,
    .qm_tag, .target_queue_tag, .qm_feat, .sdb_valid, .sdb_act, .resp_valid,
    .resp_err, .resp_abrt, .write_not_continue_bit, .read_not_continue_bit,
    .sec_valid, .sec_write, .sec_lba, .sec_elem, .sec_pred,
    .rebuild_assist_bypass_bit, .sec_last, .sec_err, .qlog_valid);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 50)
    begin
      fail_count++;
      $display("BAD %0t bus answer timed out", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
    input logic exp_err = 1'b0);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    chk(d, exp);
    chk(e, exp_err);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask

  task automatic qm(input logic [4:0] own, input logic [4:0] tgt,
    input logic [7:0] feat, input logic err, input logic [31:0] act,
    input logic wa = 1'b0, input logic [4:0] at = 5'h0);
    u_host.qm_cmd(own, tgt, feat, wa, at);
    #1;
    chk(resp_valid, 1'b1);
    chk({resp_err, resp_abrt}, {err, err});
    chk(sdb_valid, act != 0);
    chk(sdb_act, act);
  endtask

  task automatic sec(input logic [47:0] lba, input logic [4:0] el,
    input logic pr, input logic wr_n, input logic byp, input logic last,
    input logic exp);
    u_host.sector(lba, el, pr, wr_n, byp, last);
    #1;
    chk(sec_err, exp);
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    #50us;
    fail_count++;
    stop_test();
  end

  initial
  begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rd(nqr_pkg::OFF_CTRL, 32'h1);
    rd(nqr_pkg::OFF_QLOG0, 32'h1f);
    rd(nqr_pkg::OFF_QLOG1, 32'h7);
    rd(nqr_pkg::OFF_QVER, 32'h1);
    rd(nqr_pkg::OFF_RBLEN, 32'h1);
    rd(8'h38, 32'h0, 1'b1);
    wr(nqr_pkg::OFF_RBLEN, 32'h5);
    wr(nqr_pkg::OFF_RBMASK, 32'hff);
    rd(nqr_pkg::OFF_RBLEN, 32'h1);
    rd(nqr_pkg::OFF_RBMASK, 32'hf);
    wr(nqr_pkg::OFF_RBDIS, 32'hff);
    rd(nqr_pkg::OFF_RBDIS, 32'hf);
    u_host.accept(5'd3, 1'b0);
    u_host.accept(5'd5, 1'b1);
    u_host.accept(5'd6, 1'b1);
    qm(5'd7, 5'd3, 8'h10, 1'b0, 32'h0000_00e0);
    rd(nqr_pkg::OFF_OUTST, 32'h8);
    qm(5'd7, 5'd7, 8'h00, 1'b1, 32'h0);
    qm(5'd7, 5'd20, 8'h00, 1'b1, 32'h0);
    qm(5'd7, 5'd3, 8'h40, 1'b1, 32'h0);
    qm(5'd7, 5'd7, 8'h01, 1'b1, 32'h0);
    qm(5'd7, 5'd20, 8'h31, 1'b1, 32'h0);
    qm(5'd7, 5'd3, 8'hc1, 1'b1, 32'h0);
    rd(nqr_pkg::OFF_OUTST, 32'h8);
    rd(nqr_pkg::OFF_STAT, 32'h4);
    qm(5'd7, 5'd3, 8'h30, 1'b0, 32'h88, 1'b1, 5'd9);
    rd(nqr_pkg::OFF_OUTST, 32'h200);
    qm(5'd1, 5'd2, 8'h20, 1'b0, 32'h202);
    qm(5'd4, 5'd5, 8'h00, 1'b0, 32'h10);
    qm(5'd2, 5'd3, 8'h31, 1'b0, 32'h4);
    chk(dl_bits, 2'b11);
    @(posedge core_clk);
    soft_reset <= 1'b1;
    @(posedge core_clk);
    soft_reset <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(dl_bits, 2'b11);
    // a finished tag leaves the queue, the other stays
    u_host.accept(5'd4, 1'b0);
    u_host.accept(5'd8, 1'b0);
    u_host.complete(5'd4);
    rd(nqr_pkg::OFF_OUTST, 32'h100);
    qm(5'd1, 5'd3, 8'h02, 1'b1, 32'h0, 1'b0);
    rd(nqr_pkg::OFF_OUTST, 32'h0);
    wr(nqr_pkg::OFF_CTRL, 32'h2);
    qm(5'd1, 5'd2, 8'h00, 1'b1, 32'h0);
    qm(5'd1, 5'd2, 8'h01, 1'b1, 32'h0);
    wr(nqr_pkg::OFF_CTRL, 32'h3);
    // run breaks at 0c, so final stays at 0b
    sec(48'h1_0000_000a, 5'd0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    sec(48'h1_0000_000b, 5'd0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    sec(48'h1_0000_000d, 5'd0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    repeat (2) @(posedge core_clk);
    #1;
    chk(qlog_seen, 1'b1);
    rd(nqr_pkg::OFF_QESNS, 32'h000b_1103);
    rd(nqr_pkg::OFF_QELBA_LO, 32'ha);
    rd(nqr_pkg::OFF_QELBA_HI, 32'h1);
    rd(nqr_pkg::OFF_QEFIN_LO, 32'hb);
    rd(nqr_pkg::OFF_QEFIN_HI, 32'h1);
    qlog_seen = 1'b0;
    u_host.sector(48'h14, 5'd0, 1'b1, 1'b0, 1'b1, 1'b1);
    repeat (3) @(posedge core_clk);
    #1;
    chk(qlog_seen, 1'b0);
    sec(48'h1e, 5'd2, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    sec(48'h20, 5'd1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    wr(nqr_pkg::OFF_RBDIS, 32'h0);
    sec(48'h1e, 5'd2, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk(dl_bits, 2'b00);
    rd(nqr_pkg::OFF_CTRL, 32'h1);
    stop_test();
  end
endmodule
